// ---- include/wei_pkg.sv ----
// Package with register layout and timing constants of the wake event indicator
package wei_pkg;
  // Power event control register offset (byte address on the device bus)
  localparam logic [7:0]  WEI_OFS_PEC        = 8'h84;
  localparam logic [7:0]  WEI_OFS_BYTE_TEST  = 8'h64;
  localparam logic [7:0]  WEI_OFS_HW_CONFIG  = 8'h74;
  // Field positions
  localparam int          WEI_BIT_READY      = 0;
  localparam int          WEI_BIT_OUT_EN     = 1;
  localparam int          WEI_BIT_POL        = 2;
  localparam int          WEI_BIT_PULSE      = 3;
  localparam int          WEI_BIT_CAUSE_LO   = 4;
  localparam int          WEI_BIT_CAUSE_HI   = 5;
  localparam int          WEI_BIT_DRIVE      = 6;
  localparam int          WEI_BIT_ENERGY_EN  = 8;
  localparam int          WEI_BIT_WF_EN      = 9;
  localparam int          WEI_BIT_MODE_LO    = 12;
  localparam int          WEI_BIT_MODE_HI    = 13;
  // Wake cause and power mode encodings
  localparam logic [1:0]  WEI_CAUSE_NONE     = 2'h0;
  localparam logic [1:0]  WEI_CAUSE_ENERGY   = 2'h1;
  localparam logic [1:0]  WEI_CAUSE_FRAME    = 2'h2;
  localparam logic [1:0]  WEI_CAUSE_MULTI    = 2'h3;
  localparam logic [1:0]  WEI_MODE_NORMAL    = 2'h0;
  localparam logic [1:0]  WEI_MODE_FRAME     = 2'h1;
  localparam logic [1:0]  WEI_MODE_ENERGY    = 2'h2;
  localparam logic [1:0]  WEI_MODE_RSVD      = 2'h3;
  // Timing
  localparam int          WEI_CLK_MHZ        = 40;
  localparam int          WEI_PULSE_MS       = 50;
  localparam int          WEI_PULSE_CYC      = WEI_PULSE_MS * 1000 * WEI_CLK_MHZ;
  localparam int          WEI_READY_CYC      = 16;
  localparam int          WEI_CNT_W          = 22;
  // Host command register offsets (controller side)
  localparam logic [3:0]  WEI_HC_CMD         = 4'h0;
  localparam logic [3:0]  WEI_HC_WDATA       = 4'h4;
  localparam logic [3:0]  WEI_HC_RDATA       = 4'h8;
  localparam logic [3:0]  WEI_HC_STATUS      = 4'hC;
  localparam logic [3:0]  WEI_HC_ADDR        = 4'h1;
endpackage : wei_pkg

// ---- include/wei_if.sv ----
// Interface joining host controller and wake event indicator device
`timescale 1ns/100ps
interface wei_if;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic        wr;
  logic        rd;
  logic        wake_pin_o;
  logic        wake_pin_oe;
  logic        wake_pin_line;
  // Pulled high while released
  assign wake_pin_line = wake_pin_oe ? wake_pin_o : 1'b1;
  modport device (input addr, input wdata, input wr, input rd, output rdata,
                  output wake_pin_o, output wake_pin_oe);
  modport host (output addr, output wdata, output wr, output rd, input rdata,
                input wake_pin_line);
endinterface : wei_if

// ---- src/wei_device.sv ----
// Wake event indicator: power event control register and power event pin
//
// The placing of the registers and strobed register access were decided locally.
`timescale 1ns/100ps
module wei_device
  import wei_pkg::*;
#(
  parameter int PULSE_CYC = WEI_PULSE_CYC
)(
  input  wire logic clk,
  input  wire logic rst,
  wei_if.device     bus,
  input  wire logic energy_evt,
  input  wire logic frame_evt,
  output logic      power_event_irq,
  output logic [1:0] power_state
);
  logic [1:0]         wake_cause_r;
  logic [1:0]         power_state_sel_r;
  logic               wake_out_pulse_sel_r;
  logic               wake_out_polarity_r;
  logic               wake_out_enable_r;
  logic               wake_out_drive_type_r;
  logic               energy_wake_enable_r;
  logic               wake_frame_enable_r;
  logic               ready_r;
  logic [4:0]         rdy_cnt_r;
  logic               active_r;
  logic [WEI_CNT_W-1:0] pulse_cnt_r;
  logic [31:0]        rdata_r;
  logic [1:0]         e_sync_r;
  logic [1:0]         f_sync_r;
  logic               e_hit;
  logic               f_hit;
  logic               pec_wr;
  logic [1:0]         clr_mask;
  logic               irq_r;

  // Event inputs are asynchronous pins
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      e_sync_r <= 2'h0;
      f_sync_r <= 2'h0;
    end
    else
    begin
      e_sync_r <= {e_sync_r[0], energy_evt};
      f_sync_r <= {f_sync_r[0], frame_evt};
    end
  end

  assign e_hit  = e_sync_r[1] & energy_wake_enable_r;
  assign f_hit  = f_sync_r[1] & wake_frame_enable_r;
  assign pec_wr = bus.wr && (bus.addr == WEI_OFS_PEC);
  // Clear only allowed when back in normal mode with ready set
  assign clr_mask = (pec_wr && ready_r && power_state_sel_r == WEI_MODE_NORMAL) ?
                    bus.wdata[WEI_BIT_CAUSE_HI:WEI_BIT_CAUSE_LO] : 2'h0;

  // Cause bits: set wins over clear, sources keep them set
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      wake_cause_r <= WEI_CAUSE_NONE;
    else
      wake_cause_r <= (wake_cause_r & ~clr_mask)
                      | {f_hit, e_hit};
  end

  // Control bits
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wake_out_pulse_sel_r  <= 1'b0;
      wake_out_polarity_r   <= 1'b0;
      wake_out_enable_r     <= 1'b0;
      wake_out_drive_type_r <= 1'b0;
      energy_wake_enable_r  <= 1'b0;
      wake_frame_enable_r   <= 1'b0;
    end
    else if (pec_wr)
    begin
      wake_out_pulse_sel_r  <= bus.wdata[WEI_BIT_PULSE];
      wake_out_polarity_r   <= bus.wdata[WEI_BIT_POL];
      wake_out_enable_r     <= bus.wdata[WEI_BIT_OUT_EN];
      wake_out_drive_type_r <= bus.wdata[WEI_BIT_DRIVE];
      energy_wake_enable_r  <= bus.wdata[WEI_BIT_ENERGY_EN];
      wake_frame_enable_r   <= bus.wdata[WEI_BIT_WF_EN];
    end
  end

  // Power state: host selects reduced mode, byte test write wakes
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      power_state_sel_r <= WEI_MODE_NORMAL;
    else if (bus.wr && bus.addr == WEI_OFS_BYTE_TEST)
      power_state_sel_r <= WEI_MODE_NORMAL;
    else if (power_state_sel_r != WEI_MODE_NORMAL && (e_hit || f_hit))
      power_state_sel_r <= WEI_MODE_NORMAL;
    else if (pec_wr && bus.wdata[WEI_BIT_MODE_HI:WEI_BIT_MODE_LO] != WEI_MODE_RSVD)
      power_state_sel_r <= bus.wdata[WEI_BIT_MODE_HI:WEI_BIT_MODE_LO];
  end

  // Ready: settles a fixed count after entering normal mode
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rdy_cnt_r <= 5'h00;
      ready_r   <= 1'b0;
    end
    else if (power_state_sel_r != WEI_MODE_NORMAL)
    begin
      rdy_cnt_r <= 5'h00;
      ready_r   <= 1'b0;
    end
    else if (rdy_cnt_r == 5'(WEI_READY_CYC))
      ready_r <= 1'b1;
    else
      rdy_cnt_r <= rdy_cnt_r + 5'h01;
  end

  // Output activity and pulse timer
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      active_r    <= 1'b0;
      pulse_cnt_r <= '0;
    end
    else if (!wake_out_enable_r || wake_cause_r == WEI_CAUSE_NONE)
    begin
      active_r    <= 1'b0;
      pulse_cnt_r <= '0;
    end
    else if ((e_hit || f_hit) && !active_r && pulse_cnt_r == '0)
    begin
      active_r    <= 1'b1;
      pulse_cnt_r <= WEI_CNT_W'(PULSE_CYC);
    end
    else if (wake_out_pulse_sel_r && active_r)
    begin
      if (pulse_cnt_r == WEI_CNT_W'(1))
        active_r <= 1'b0;
      pulse_cnt_r <= pulse_cnt_r - WEI_CNT_W'(1);
    end
  end

  // Internal interrupt independent of external enable
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      irq_r <= 1'b0;
    else
      irq_r <= wake_cause_r != WEI_CAUSE_NONE;
  end
  assign power_event_irq = irq_r;
  assign power_state     = power_state_sel_r;

  // Pin drive: open-drain pulls low when active, push-pull uses polarity
  always_comb
  begin
    if (!wake_out_drive_type_r)
    begin
      bus.wake_pin_o  = 1'b0;
      bus.wake_pin_oe = active_r;
    end
    else
    begin
      bus.wake_pin_o  = active_r ~^ wake_out_polarity_r;
      bus.wake_pin_oe = 1'b1;
    end
  end

  // Read data, one cycle after strobe, valid in every mode
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      rdata_r <= 32'h0000_0000;
    else if (bus.rd && bus.addr == WEI_OFS_PEC)
    begin
      rdata_r <= 32'h0000_0000;
      rdata_r[WEI_BIT_MODE_HI:WEI_BIT_MODE_LO]   <= power_state_sel_r;
      rdata_r[WEI_BIT_WF_EN]                     <= wake_frame_enable_r;
      rdata_r[WEI_BIT_ENERGY_EN]                 <= energy_wake_enable_r;
      rdata_r[WEI_BIT_DRIVE]                     <= wake_out_drive_type_r;
      rdata_r[WEI_BIT_CAUSE_HI:WEI_BIT_CAUSE_LO] <= wake_cause_r;
      rdata_r[WEI_BIT_PULSE]                     <= wake_out_pulse_sel_r;
      rdata_r[WEI_BIT_POL]                       <= wake_out_polarity_r;
      rdata_r[WEI_BIT_OUT_EN]                    <= wake_out_enable_r;
      rdata_r[WEI_BIT_READY]                     <= ready_r;
    end
    else
      rdata_r <= 32'h0000_0000;
  end
  assign bus.rdata = rdata_r;
endmodule : wei_device

// ---- src/wei_host.sv ----
// Host controller: forwards software accesses, refuses all but PEC, HW config and byte test while not ready
`timescale 1ns/100ps
module wei_host
  import wei_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  wei_if.host              bus,
  input  wire logic [3:0]  sw_addr,
  input  wire logic [31:0] sw_wdata,
  input  wire logic        sw_wr,
  input  wire logic        sw_rd,
  output logic [31:0]      sw_rdata,
  output logic             power_event_seen
);
  logic [7:0]  addr_r;
  logic [31:0] wdata_r;
  logic [31:0] cmd_data_r;
  logic [31:0] rbuf_r;
  logic [31:0] sw_rdata_r;
  logic        wr_r;
  logic        rd_r;
  logic        rd_pend_r;
  logic        ready_seen_r;
  logic        refused_r;
  logic [1:0]  pin_sync_r;
  logic [7:0]  cmd_addr;
  logic        allowed;
  logic        is_cfg;
  logic        go_wr;
  logic        go_rd;

  // Judged on the address issued with the command, not the previous one
  assign cmd_addr = sw_wdata[7:0];
  assign is_cfg  = cmd_addr == WEI_OFS_PEC || cmd_addr == WEI_OFS_HW_CONFIG;
  assign allowed = ready_seen_r || is_cfg || (cmd_addr == WEI_OFS_BYTE_TEST);
  assign go_wr   = sw_wr && sw_addr == WEI_HC_CMD && sw_wdata[8];
  assign go_rd   = sw_wr && sw_addr == WEI_HC_CMD && sw_wdata[9];

  // Software-programmed address and data
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      addr_r     <= 8'h00;
      cmd_data_r <= 32'h0000_0000;
    end
    else if (sw_wr)
    begin
      if (sw_addr == WEI_HC_CMD)
        addr_r <= sw_wdata[7:0];
      if (sw_addr == WEI_HC_WDATA)
        cmd_data_r <= sw_wdata;
    end
  end

  // Device strobes, one cycle each
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wr_r      <= 1'b0;
      rd_r      <= 1'b0;
      wdata_r   <= 32'h0000_0000;
      refused_r <= 1'b0;
    end
    else
    begin
      wr_r    <= go_wr && allowed && !go_rd;
      rd_r    <= go_rd && allowed && !go_wr;
      wdata_r <= cmd_data_r;
      if (go_wr || go_rd)
        refused_r <= !allowed;
    end
  end
  assign bus.addr  = addr_r;
  assign bus.wdata = wdata_r;
  assign bus.wr    = wr_r;
  assign bus.rd    = rd_r;

  // Capture read data, track ready bit of control register
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rd_pend_r    <= 1'b0;
      rbuf_r       <= 32'h0000_0000;
      ready_seen_r <= 1'b0;
    end
    else
    begin
      rd_pend_r <= rd_r;
      if (rd_pend_r)
      begin
        rbuf_r <= bus.rdata;
        if (addr_r == WEI_OFS_PEC)
          ready_seen_r <= bus.rdata[WEI_BIT_READY];
      end
      else if (wr_r && addr_r == WEI_OFS_PEC &&
               bus.wdata[WEI_BIT_MODE_HI:WEI_BIT_MODE_LO] != WEI_MODE_NORMAL)
        ready_seen_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      pin_sync_r <= 2'h0;
    else
      pin_sync_r <= {pin_sync_r[0], bus.wake_pin_line};
  end
  assign power_event_seen = pin_sync_r[1];

  // Software read port
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      sw_rdata_r <= 32'h0000_0000;
    else if (sw_rd && sw_addr == WEI_HC_RDATA)
      sw_rdata_r <= rbuf_r;
    else if (sw_rd && sw_addr == WEI_HC_STATUS)
      sw_rdata_r <= {28'h0, pin_sync_r[1], refused_r, rd_pend_r | rd_r, ready_seen_r};
    else
      sw_rdata_r <= 32'h0000_0000;
  end
  assign sw_rdata = sw_rdata_r;
endmodule : wei_host

// ---- verif/wei_chk_sva.sv ----
// Checker for the wake pin and register bus between host and device
`timescale 1ns/100ps
module wei_chk
  import wei_pkg::*;
#(
  parameter int PULSE_CYC = WEI_PULSE_CYC
)(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [7:0]  addr,
  input wire logic [31:0] wdata,
  input wire logic [31:0] rdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic        wake_pin_o,
  input wire logic        wake_pin_oe,
  input wire logic        wake_pin_line
);
  logic [3:0] cfg_r;
  logic [7:0] age_r;
  int         cnt_r;
  logic       act;
  logic       rd_pec;
  // Drive, pulse, polarity, enable as last written
  assign act = (cfg_r[3] & cfg_r[1]) ? wake_pin_line : ~wake_pin_line;
  assign rd_pec = rd && addr == WEI_OFS_PEC;
  always_ff @(posedge clk or posedge rst)
    if (rst) cfg_r <= 4'h0;
    else if (wr && addr == WEI_OFS_PEC) cfg_r <= {wdata[6], wdata[3:1]};
  always_ff @(posedge clk or posedge rst)
    if (rst) age_r <= 8'h00;
    else if (age_r != 8'hFF) age_r <= age_r + 8'h01;
  always_ff @(posedge clk or posedge rst)
    if (rst) cnt_r <= 0;
    else cnt_r <= act ? cnt_r + 1 : 0;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_quiet;
    !wr [*3];
  endsequence
  property p_od_low; s_quiet ##0 !cfg_r[3] |-> !wake_pin_o; endproperty
  property p_pp_on; s_quiet ##0 cfg_r[3] |-> wake_pin_oe; endproperty
  property p_off_idle; s_quiet ##0 !cfg_r[0] |-> !act; endproperty
  property p_pulse_len; s_quiet ##0 ($fell(act) && cfg_r[2]) |-> cnt_r == PULSE_CYC; endproperty
  property p_static; s_quiet ##0 (act && !cfg_r[2]) |=> act; endproperty
  property p_rsvd_mode; rd_pec |=> rdata[13:12] != 2'h3; endproperty
  property p_resv_bits; rd_pec |=> rdata[31:14] == 18'h0 && !rdata[11] && !rdata[7]; endproperty
  property p_ready_wait; rd_pec && age_r < 8'h0F |=> !rdata[0]; endproperty
  a_od_low: assert property (p_od_low)
    else $error("open drain pin driven high");
  a_pp_on: assert property (p_pp_on)
    else $error("push pull pin not driven");
  a_off_idle: assert property (p_off_idle)
    else $error("pin active while disabled");
  a_pulse_len: assert property (p_pulse_len)
    else $error("pulse length wrong");
  a_static: assert property (p_static)
    else $error("static output dropped");
  a_rsvd_mode: assert property (p_rsvd_mode)
    else $error("reserved mode stored");
  a_resv_bits: assert property (p_resv_bits)
    else $error("reserved bits set");
  a_ready_wait: assert property (p_ready_wait)
    else $error("ready set too early");
endmodule : wei_chk

// ---- verif/wake_event_indicator_tb_top.sv ----
// Self-checking bench for the host and device pair
`timescale 1ns/100ps
module wake_event_indicator_tb_top;
  import wei_pkg::*;
  logic        clk = 0, rst = 1, e_evt = 0, f_evt = 0, sw_wr = 0, sw_rd = 0;
  logic [3:0]  sw_addr = 4'h0;
  logic [31:0] sw_wdata = 32'h0, sw_rdata, rv;
  logic        irq, seen;
  logic [1:0]  pstate;
  int          mismatches = 0, num_checks = 0, seed = 32'hd864;
  int          mode = 0, cfg = 0, cause = 0, live = 0;
  always #12.5 clk = ~clk;
  wei_if bus ();
  wei_device #(.PULSE_CYC(20)) u_wei_device (.clk(clk), .rst(rst), .bus(bus),
    .energy_evt(e_evt), .frame_evt(f_evt), .power_event_irq(irq), .power_state(pstate));
  wei_host u_wei_host (.clk(clk), .rst(rst), .bus(bus), .sw_addr(sw_addr),
    .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata),
    .power_event_seen(seen));
  wei_chk #(.PULSE_CYC(20)) u_wei_chk (.clk(clk), .rst(rst), .addr(bus.addr),
    .wdata(bus.wdata), .rdata(bus.rdata), .wr(bus.wr), .rd(bus.rd),
    .wake_pin_o(bus.wake_pin_o), .wake_pin_oe(bus.wake_pin_oe),
    .wake_pin_line(bus.wake_pin_line));
  task automatic finish_test();
    if (mismatches == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : finish_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // One software strobe; read data caught in the following cycle
  task automatic sw(input logic [3:0] a, input logic [31:0] d, input logic w);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= w;
    sw_rd <= !w;
    @(posedge clk);
    sw_wr <= 1'b0;
    sw_rd <= 1'b0;
    #1 rv = sw_rdata;
    @(posedge clk);
  endtask : sw
  task automatic dev(input logic [7:0] a, input logic [31:0] d, input logic w);
    if (w) sw(WEI_HC_WDATA, d, 1'b1);
    sw(WEI_HC_CMD, {22'h0, !w, w, a}, 1'b1);
    repeat (3) @(posedge clk);
    for (int i = 0; i < 20; i++)
    begin
      sw(WEI_HC_STATUS, 32'h0, 1'b0);
      if (rv[1] === 1'b0) break;
      if (i == 19)
      begin
        mismatches++;
        finish_test();
      end
    end
    if (!w) sw(WEI_HC_RDATA, 32'h0, 1'b0);
  endtask : dev
  // Model update on a control write; reserved bits 31:14 and 7 get random noise
  task automatic wr84(input int v);
    dev(WEI_OFS_PEC, v | ($random(seed) & 32'hFFFFC080), 1'b1);
    cfg = v & 32'h34E;
    if (mode == 0) cause = (cause & ~(v >> 4) & 3) | live;
    if (((v >> 12) & 3) != 3) mode = (v >> 12) & 3;
  endtask : wr84
  task automatic rd84(input int rdy, input logic [31:0] m = 32'hFFFFFFFF);
    dev(WEI_OFS_PEC, 32'h0, 1'b0);
    chk(rv & m, 32'((mode << 12) | cfg | (cause << 4) | rdy) & m);
  endtask : rd84
  // Pin and irq sampled mid-cycle, away from the edge that updates them
  task automatic pin(input int act);
    repeat (7) @(posedge clk);
    @(negedge clk);
    chk(32'({irq, seen}), 32'({cause != 0, (cfg[6] && cfg[2]) ? act[0] : !act[0]}));
    @(posedge clk);
  endtask : pin
  task automatic wake();
    dev(WEI_OFS_BYTE_TEST, 32'h0, 1'b1);
    mode = 0;
    repeat (20) @(posedge clk);
  endtask : wake
  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd84(0);
    dev(8'h88, 32'h0, 1'b0);
    sw(WEI_HC_STATUS, 32'h0, 1'b0);
    chk(32'(rv[2]), 32'h1);
    repeat (20) @(posedge clk);
    rd84(1);
    for (int m = 1; m < 4; m++)
    begin
      wr84(m << 12);
      chk(32'(pstate), 32'(mode));
      rd84(1, 32'hFFFFFFFE);
      wake();
      rd84(1);
    end
    wr84(32'h346);
    e_evt <= 1'b1;
    live = 1;
    cause = 1;
    pin(1);
    rd84(1);
    f_evt <= 1'b1;
    live = 3;
    cause = 3;
    pin(1);
    rd84(1);
    wr84(32'h376);
    rd84(1);
    e_evt <= 1'b0;
    f_evt <= 1'b0;
    live = 0;
    repeat (4) @(posedge clk);
    wr84(32'h376);
    pin(0);
    rd84(1);
    wr84(32'h20E);
    f_evt <= 1'b1;
    live = 2;
    cause = 2;
    repeat (3) @(posedge clk);
    f_evt <= 1'b0;
    live = 0;
    pin(1);
    repeat (30) @(posedge clk);
    pin(0);
    wr84(32'h23E);
    pin(0);
    wr84(32'h144);
    e_evt <= 1'b1;
    live = 1;
    cause = 1;
    pin(0);
    e_evt <= 1'b0;
    live = 0;
    wr84(32'h2144);
    wr84(32'h2174);
    rd84(1, 32'hFFFFFFFE);
    wake();
    wr84(32'h174);
    rd84(1);
    finish_test();
  end
endmodule : wake_event_indicator_tb_top
